// ==== psc_consts.svh ====
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH
// ---------------------------------------------
// special register numbers
// ---------------------------------------------
`define PSC_SPR_SAVED 8'h01
`define PSC_SPR_CPS 8'h02
`define PSC_SPR_CFG 8'h03
`define PSC_SPR_UNPROT_LO 8'h80
`define PSC_SPR_VIRT_LO 8'hA0
// ---------------------------------------------
// field widths, positions and reset values
// ---------------------------------------------
`define PSC_CPS_W 16
`define PSC_CFG_W 6
`define PSC_PRL_LSB 24
`define PSC_CPS_RST 16'h0173
`define PSC_CFG_RST 6'h00
`define PSC_VEC_TBL_PAD 6'h00
`define PSC_VEC_BLK_PAD 8'h00
`define PSC_VEC_TBL_LO 2'h0
`endif

// ==== psc_pkg.sv ====
package psc_pkg;
  // current / saved status layout, bit 15 first
  typedef struct packed {
    logic coproc_busy;
    logic masked_irq_seen;
    logic trace_enable;
    logic trace_pending;
    logic trap_unaligned;
    logic freeze_state;
    logic atomic_hold_bit;
    logic rom_fetch_enable;
    logic idle_mode_bit;
    logic physical_data_bit;
    logic physical_fetch_bit;
    logic supervisor_bit;
    logic [1:0] interrupt_priority_mask;
    logic external_irq_block;
    logic all_exception_block;
  } psc_status_t;
  // writable configuration bits 5..0
  typedef struct packed {
    logic narrow_access_enable;
    logic vector_layout_select;
    logic vector_in_rom;
    logic byte_order_bit;
    logic coproc_present;
    logic branch_cache_off;
  } psc_cfg_t;
  // external data access presented for checking
  typedef struct packed {
    logic valid;
    logic is_io;
    logic is_cop;
    logic word;
    logic half;
    logic byte_acc;
    logic physical_address_bit;
    logic user_access_override;
    logic [1:0] addr_lo;
  } psc_acc_t;
endpackage

// ==== psc_regs.sv ====
`timescale 1ns/100ps
`include "psc_consts.svh"
module psc_regs
  import psc_pkg::*;
#(
  parameter logic [7:0] RELEASE_LEVEL = 8'h00, // arbitrary value
  parameter int IRQ_LINES = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // special register moves
  input wire logic spr_rd,
  input wire logic spr_wr,
  input wire logic [7:0] spr_num,
  input wire logic [31:0] spr_wdata,
  output logic [31:0] spr_rdata,
  output logic prot_trap,
  // pipeline events
  input wire logic instr_done,
  input wire logic exc_take,
  input wire logic exc_return,
  input wire logic branch_exec,
  input wire logic cop_set,
  input wire logic cop_clr,
  input wire logic lock_instr,
  // interrupt pins
  input wire logic [IRQ_LINES-1:0] ext_irq_lines,
  // exception gating
  output logic ext_irq_take,
  output logic trap_allow,
  output logic trace_trap,
  // data access checking
  input wire psc_acc_t acc,
  output logic unaligned_trap,
  output logic cop_np_trap,
  output logic narrow_emul_trap,
  output logic xlate_data,
  output logic acc_user,
  // fetch and mode controls
  output logic fetch_target_type,
  output logic xlate_fetch,
  output logic freeze_hold,
  output logic lock_out,
  output logic idle,
  output logic byte_order_bit,
  output logic branch_cache_off,
  // vector generation
  input wire logic [15:0] vec_base,
  input wire logic [7:0] vec_num,
  output logic [31:0] vec_addr,
  output logic vec_from_rom
);

  // ---------------------------------------------
  // helper functions
  // ---------------------------------------------
  // lines enabled by the priority mask, 0 up to the mask value
  // the count is widened first so mask 3 cannot wrap to zero lines
  function automatic logic [IRQ_LINES-1:0] im_lines(input logic [1:0] im);
    logic [IRQ_LINES:0] m; // one spare bit above the shifted one
    logic [2:0] n; // number of enabled lines
    n = {1'b0, im} + 3'h1;
    m = ({{IRQ_LINES{1'b0}}, 1'b1} << n) - 1'b1;
    return m[IRQ_LINES-1:0];
  endfunction

  // misaligned data address for word or half
  function automatic logic misaligned(input psc_acc_t a);
    if (a.word) begin
      return |a.addr_lo;
    end else if (a.half) begin
      return a.addr_lo[0];
    end
    return 1'b0;
  endfunction

  // status as it reads back, reserved upper half forced to zero
  function automatic logic [31:0] status_word(input psc_status_t s);
    return {{(32-`PSC_CPS_W){1'b0}}, s};
  endfunction

  // status bits taken from a moved word, reserved bits dropped
  function automatic psc_status_t status_from(input logic [31:0] w);
    return psc_status_t'(w[`PSC_CPS_W-1:0]);
  endfunction

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  psc_status_t cps_r, cps_nxt; // current status
  psc_status_t ops_r, ops_nxt; // saved status
  psc_cfg_t cfg_r, cfg_nxt; // configuration
  logic cdoff_r, cdoff_nxt; // effective cache disable
  logic [31:0] rdata_r, rdata_nxt; // read data
  logic [31:0] vaddr_r, vaddr_nxt; // vector address
  logic vrom_r, vrom_nxt; // vector fetch from rom
  // pin synchroniser, three stages
  logic [IRQ_LINES-1:0] irq_s1_r, irq_s2_r, irq_s3_r;
  logic [IRQ_LINES-1:0] irq_s1_nxt, irq_s2_nxt, irq_s3_nxt; // stage inputs
  logic [IRQ_LINES-1:0] irq_q_r, irq_q_nxt; // agreed level

  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  logic acc_req; // any move
  logic prot_num; // numbers below unprotected window
  logic virt_num; // virtual registers, never reachable
  logic wr_ok; // write permitted
  logic rd_ok; // read permitted
  logic any_act; // any line active
  logic blocked; // active but not takeable

  always_comb begin
    // a move is either strobe for one cycle
    acc_req = spr_rd | spr_wr;
    // 0x80 to 0x9F stay open to user code
    prot_num = spr_num < `PSC_SPR_UNPROT_LO;
    virt_num = spr_num >= `PSC_SPR_VIRT_LO;
    // user mode may not touch protected numbers
    prot_trap = acc_req & (virt_num | (prot_num & ~cps_r.supervisor_bit));
    // a refused move neither writes nor disturbs read data
    wr_ok = spr_wr & ~prot_trap;
    rd_ok = spr_rd & ~prot_trap;
    // any line at all, enabled or not
    any_act = |irq_q_r;
    // take an external line only if no block applies
    ext_irq_take = |(irq_q_r & im_lines(cps_r.interrupt_priority_mask))
      & ~cps_r.external_irq_block & ~cps_r.all_exception_block;
    // blocked covers the global, external and mask gates alike
    blocked = any_act & ~ext_irq_take;
  end

  // ---------------------------------------------
  // register next-state
  // ---------------------------------------------
  // software moves first, hardware updates last so they win
  always_comb begin
    cps_nxt = cps_r;
    ops_nxt = ops_r;
    cfg_nxt = cfg_r;
    cdoff_nxt = cdoff_r;
    rdata_nxt = rdata_r;
    irq_q_nxt = irq_q_r;
    // moves complete in a single cycle
    // status and saved status share one layout
    if (wr_ok) begin
      case (spr_num)
        `PSC_SPR_CPS: cps_nxt = status_from(spr_wdata);
        `PSC_SPR_SAVED: ops_nxt = status_from(spr_wdata);
        `PSC_SPR_CFG: cfg_nxt = psc_cfg_t'(spr_wdata[`PSC_CFG_W-1:0]);
        default: ; // other numbers live elsewhere
      endcase
    end
    // interrupt return restores saved status
    // a return in the same cycle as a status move overrides the move
    if (exc_return) begin
      cps_nxt = ops_r;
    end
    // coprocessor activity marker
    // set wins when both strobes meet, so a started transfer is not lost
    if (cop_set) begin
      cps_nxt.coproc_busy = 1'b1;
    end else if (cop_clr) begin
      cps_nxt.coproc_busy = 1'b0;
    end
    // masked interrupt seen
    // limitation: a flag raised by the mask alone stays up until software clears it
    if (blocked) begin
      cps_nxt.masked_irq_seen = 1'b1;
    end else if (~any_act & (cps_r.external_irq_block | cps_r.all_exception_block)) begin
      cps_nxt.masked_irq_seen = 1'b0;
    end
    // single-step emulation
    // the copy uses the enable as it stood before this cycle's move
    if (instr_done) begin
      cps_nxt.trace_pending = cps_r.trace_enable;
    end
    // exception entry: save, freeze, wake
    // entry outranks everything, so the saved copy is the status before entry
    if (exc_take) begin
      ops_nxt = cps_r;
      cps_nxt.freeze_state = 1'b1;
      cps_nxt.idle_mode_bit = 1'b0;
    end
    // cache disable only changes on a branch
    // a change mid-stream would split a fetch run, so it waits for a branch
    if (branch_exec) begin
      cdoff_nxt = cfg_r.branch_cache_off;
    end
    // the lines count once the last two stages agree on every line
    // a line caught changing between stages holds every line at its old agreed level
    if (irq_s2_r == irq_s3_r) begin
      irq_q_nxt = irq_s3_r;
    end
    // registered read-back, reserved bits zero
    // a refused read leaves the previous data standing
    if (rd_ok) begin
      case (spr_num)
        `PSC_SPR_CPS: rdata_nxt = status_word(cps_r);
        `PSC_SPR_SAVED: rdata_nxt = status_word(ops_r);
        `PSC_SPR_CFG: rdata_nxt = {RELEASE_LEVEL,
          {(`PSC_PRL_LSB-`PSC_CFG_W){1'b0}}, cfg_r};
        default: rdata_nxt = '0; // unimplemented here
      endcase
    end
  end

  // ---------------------------------------------
  // vector address generation
  // ---------------------------------------------
  // table entries vs 64-instruction blocks
  // the low zero pad keeps every vector word aligned
  always_comb begin
    if (cfg_r.vector_layout_select) begin
      vaddr_nxt = {vec_base, `PSC_VEC_TBL_PAD, vec_num, `PSC_VEC_TBL_LO};
      vrom_nxt = 1'b0; // table entries are data reads, never rom steered
    end else begin
      vaddr_nxt = {vec_base, vec_num, `PSC_VEC_BLK_PAD};
      vrom_nxt = cfg_r.vector_in_rom;
    end
  end

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  // reset leaves supervisor mode with every interrupt held off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cps_r <= psc_status_t'(`PSC_CPS_RST);
      ops_r <= psc_status_t'(`PSC_CPS_RST);
      cfg_r <= psc_cfg_t'(`PSC_CFG_RST);
      cdoff_r <= 1'b0;
      rdata_r <= '0;
      vaddr_r <= '0;
      vrom_r <= 1'b0;
      irq_q_r <= '0;
    end else begin
      cps_r <= cps_nxt;
      ops_r <= ops_nxt;
      cfg_r <= cfg_nxt;
      cdoff_r <= cdoff_nxt;
      rdata_r <= rdata_nxt;
      vaddr_r <= vaddr_nxt;
      vrom_r <= vrom_nxt;
      irq_q_r <= irq_q_nxt;
    end
  end

  // ---------------------------------------------
  // interrupt pin synchroniser
  // ---------------------------------------------
  // first stage feeds only the second
  always_comb begin
    irq_s1_nxt = ext_irq_lines; // raw pins, may go metastable
    irq_s2_nxt = irq_s1_r; // sole reader of the first stage
    irq_s3_nxt = irq_s2_r;
  end

  // stages only register their inputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_s1_r <= '0;
      irq_s2_r <= '0;
      irq_s3_r <= '0;
    end else begin
      irq_s1_r <= irq_s1_nxt;
      irq_s2_r <= irq_s2_nxt;
      irq_s3_r <= irq_s3_nxt;
    end
  end

  // ---------------------------------------------
  // access checks
  // ---------------------------------------------
  // io, coprocessor and fetches never alignment checked
  // all checks are combinational so a trap lands in the access cycle
  always_comb begin
    unaligned_trap = acc.valid & cps_r.trap_unaligned
      & ~acc.is_io & ~acc.is_cop & misaligned(acc);
    cop_np_trap = acc.valid & acc.is_cop & ~cfg_r.coproc_present;
    // narrow accesses emulated in software when disabled
    narrow_emul_trap = acc.valid & ~acc.is_cop & (acc.half | acc.byte_acc)
      & ~cfg_r.narrow_access_enable;
    xlate_data = acc.valid & ~cps_r.physical_data_bit
      & ~acc.physical_address_bit;
    // override makes mmu and channel treat it as user
    acc_user = ~cps_r.supervisor_bit | acc.user_access_override;
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign spr_rdata = rdata_r;
  assign vec_addr = vaddr_r;
  assign vec_from_rom = vrom_r;
  assign trap_allow = ~cps_r.all_exception_block;
  // trace is held off only by the global block
  assign trace_trap = cps_r.trace_pending & ~cps_r.all_exception_block;
  assign freeze_hold = cps_r.freeze_state;
  // a plain or, so a lock instruction is never held back a cycle
  assign lock_out = cps_r.atomic_hold_bit | lock_instr;
  assign fetch_target_type = cps_r.rom_fetch_enable;
  assign xlate_fetch = ~cps_r.physical_fetch_bit;
  assign idle = cps_r.idle_mode_bit;
  assign byte_order_bit = cfg_r.byte_order_bit;
  assign branch_cache_off = cdoff_r;

endmodule // psc_regs

// ==== psc_regs_monitor.sv ====
`timescale 1ns/100ps
module psc_regs_monitor
  import psc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs seen
  input wire logic spr_rd,
  input wire logic spr_wr,
  input wire logic [7:0] spr_num,
  input wire logic exc_take,
  input wire logic branch_exec,
  input wire logic lock_instr,
  input wire psc_acc_t acc,
  // outputs seen
  input wire logic prot_trap,
  input wire logic ext_irq_take,
  input wire logic trap_allow,
  input wire logic trace_trap,
  input wire logic unaligned_trap,
  input wire logic xlate_data,
  input wire logic acc_user,
  input wire logic freeze_hold,
  input wire logic lock_out,
  input wire logic idle,
  input wire logic branch_cache_off
);
  // one domain, so one clocking
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // checks
  // ----
  lock_pin_a: assert property (lock_instr |-> lock_out) else $error("lock pin low");
  exc_freeze_a: assert property (exc_take |=> freeze_hold && !idle) else $error("no freeze");
  virt_num_a: assert property ((spr_rd || spr_wr) && spr_num >= 8'hA0 |-> prot_trap)
    else $error("virtual number not trapped");
  io_align_a: assert property (acc.valid && (acc.is_io || acc.is_cop) |-> !unaligned_trap)
    else $error("io aligned trap");
  word_ok_a: assert property (acc.valid && acc.word && acc.addr_lo == 2'h0 |-> !unaligned_trap)
    else $error("aligned word trapped");
  // cache off only moves at a branch
  cache_off_a: assert property (!branch_exec |=> $stable(branch_cache_off)) else $error("cache bit moved");
  irq_gate_a: assert property (ext_irq_take |-> trap_allow) else $error("irq while blocked");
  trace_gate_a: assert property (trace_trap |-> trap_allow) else $error("trace while blocked");
  phys_acc_a: assert property (acc.valid && acc.physical_address_bit |-> !xlate_data)
    else $error("physical translated");
  user_acc_a: assert property (acc.valid && acc.user_access_override |-> acc_user)
    else $error("override ignored");
endmodule // psc_regs_monitor

// ==== psc_regs_tb.sv ====
`timescale 1ns/100ps
module psc_regs_tb;
  import psc_pkg::*;
  // stimulus, all set at time zero
  logic clk = 0, rst = 1, spr_rd = 0, spr_wr = 0, instr_done = 0, exc_take = 0, exc_return = 0;
  logic branch_exec = 0, cop_set = 0, cop_clr = 0, lock_instr = 0, pt;
  logic [7:0] spr_num = 8'h00, vec_num = 8'h05;
  logic [31:0] spr_wdata = 32'h0;
  logic [15:0] vec_base = 16'h1234;
  logic [3:0] ext_irq_lines = 4'h0;
  psc_acc_t acc = '0;
  // design outputs
  logic [31:0] spr_rdata, vec_addr;
  logic prot_trap, ext_irq_take, trap_allow, trace_trap, unaligned_trap, cop_np_trap, narrow_emul_trap;
  logic xlate_data, acc_user, fetch_target_type, xlate_fetch, freeze_hold, lock_out, idle;
  logic byte_order_bit, branch_cache_off, vec_from_rom;
  int err_total = 0, n_tests = 0;
  // release level value is arbitrary
  psc_regs #(.RELEASE_LEVEL(8'h5A), .IRQ_LINES(4)) DUT (.clk, .rst, .spr_rd, .spr_wr, .spr_num, .spr_wdata,
    .spr_rdata, .prot_trap, .instr_done, .exc_take, .exc_return, .branch_exec, .cop_set, .cop_clr,
    .lock_instr, .ext_irq_lines, .ext_irq_take, .trap_allow, .trace_trap, .acc, .unaligned_trap,
    .cop_np_trap, .narrow_emul_trap, .xlate_data, .acc_user, .fetch_target_type, .xlate_fetch,
    .freeze_hold, .lock_out, .idle, .byte_order_bit, .branch_cache_off, .vec_base, .vec_num,
    .vec_addr, .vec_from_rom);
  always #10 clk = ~clk;
  // ----
  // tasks
  // ----
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] n, logic [31:0] d);
    @(negedge clk);
    spr_wr = 1;
    spr_num = n;
    spr_wdata = d;
    @(negedge clk);
    spr_wr = 0;
  endtask
  // prot_trap is combinational, caught mid-cycle
  task automatic rdc(logic [7:0] n, logic [31:0] exp);
    @(negedge clk);
    spr_rd = 1;
    spr_num = n;
    #5 pt = prot_trap;
    @(negedge clk);
    spr_rd = 0;
    chk("read", exp, spr_rdata);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog, far beyond the hundred or so cycles needed
  initial begin
    #100000;
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    rdc(8'h02, 32'h00000173);
    rdc(8'h03, 32'h5A000000);
    chk("rom", 32'h1, fetch_target_type);
    chk("allow", 32'h0, trap_allow);
    wr(8'h03, 32'hFFFFFFFF);
    rdc(8'h03, 32'h5A00003F);
    chk("order", 32'h1, byte_order_bit);
    chk("cache", 32'h0, branch_cache_off);
    pulse(branch_exec);
    chk("cache", 32'h1, branch_cache_off);
    wr(8'h03, 32'h00000010);
    acc = 10'h280;
    #2 chk("copnp", 32'h1, cop_np_trap);
    @(negedge clk) acc = 10'h210;
    #2 chk("narrow", 32'h1, narrow_emul_trap);
    @(negedge clk);
    chk("vec", 32'h12340014, {vec_addr[31:1], vec_from_rom});
    wr(8'h03, 32'h00000008);
    @(negedge clk);
    chk("vec", 32'h12340501, {vec_addr[31:1], vec_from_rom});
    wr(8'h02, 32'hFFFF0010);
    rdc(8'h02, 32'h00000010);
    chk("xfetch", 32'h1, xlate_fetch);
    pulse(cop_set);
    rdc(8'h02, 32'h00008010);
    pulse(cop_clr);
    rdc(8'h02, 32'h00000010);
    wr(8'h02, 32'h00000210);
    chk("lock", 32'h1, lock_out);
    wr(8'h02, 32'h00000810);
    chk("lock", 32'h0, lock_out);
    lock_instr = 1;
    acc = 10'h242;
    #2 chk("unal", 32'h1, unaligned_trap);
    chk("lock", 32'h1, lock_out);
    chk("xdata", 32'h1, xlate_data);
    @(negedge clk) lock_instr = 0;
    acc = 10'h342;
    #2 chk("unal", 32'h0, unaligned_trap);
    @(negedge clk) acc = 10'h221;
    #2 chk("unal", 32'h1, unaligned_trap);
    @(negedge clk) acc = 10'h24C;
    #2 chk("user", 32'h1, acc_user);
    chk("xdata", 32'h0, xlate_data);
    @(negedge clk) acc = '0;
    ext_irq_lines = 4'h2;
    repeat (6) @(negedge clk);
    chk("take", 32'h0, ext_irq_take);
    rdc(8'h02, 32'h00004810);
    ext_irq_lines = 4'h1;
    repeat (6) @(negedge clk);
    chk("take", 32'h1, ext_irq_take);
    wr(8'h02, 32'h00000012);
    chk("take", 32'h0, ext_irq_take);
    ext_irq_lines = 4'h8;
    wr(8'h02, 32'h0000001C);
    repeat (6) @(negedge clk);
    chk("take", 32'h1, ext_irq_take);
    ext_irq_lines = 4'h0;
    repeat (6) @(negedge clk); // lines must read idle before the mask drops
    wr(8'h02, 32'h00002090);
    pulse(instr_done);
    rdc(8'h02, 32'h00003090);
    chk("trace", 32'h1, trace_trap);
    chk("idle", 32'h1, idle);
    pulse(exc_take);
    chk("frz", 32'h1, freeze_hold);
    chk("idle", 32'h0, idle);
    rdc(8'h01, 32'h00003090);
    wr(8'h02, 32'h00000010);
    pulse(exc_return);
    rdc(8'h02, 32'h00003090);
    rdc(8'h05, 32'h00000000);
    chk("ptrap", 32'h0, pt);
    rdc(8'hA0, 32'h00000000);
    chk("ptrap", 32'h1, pt);
    wr(8'h02, 32'h00000000);
    rdc(8'h02, 32'h00000000);
    chk("ptrap", 32'h1, pt);
    print_verdict;
  end
endmodule // psc_regs_tb
bind psc_regs psc_regs_monitor u_mon (.clk, .rst, .spr_rd, .spr_wr, .spr_num, .exc_take, .branch_exec,
  .lock_instr, .acc, .prot_trap, .ext_irq_take, .trap_allow, .trace_trap, .unaligned_trap, .xlate_data,
  .acc_user, .freeze_hold, .lock_out, .idle, .branch_cache_off);
